/* logic/cer_regs.sv */
`timescale 1ns/1ps
module cer_regs (
    input  wire logic         CLK_I,
    input  wire logic         RSTN_I,
    input  wire logic         LINK_RESET_N_I,
    input  wire logic         GLOBAL_RESET_N_I,
    input  wire logic         CFG_WR_I,
    input  wire logic         CFG_RD_I,
    input  wire logic [11:0]  CFG_ADDR_I,
    input  wire logic [3:0]   CFG_BE_I,
    input  wire logic [31:0]  CFG_WDATA_I,
    output logic      [31:0]  CFG_RDATA_O,
    output logic              CFG_RVALID_O,
    input  wire logic         PHY_DECODE_ERR_I,
    input  wire logic         RX_DLLP_ACTIVE_I,
    input  wire logic         RX_TLP_ACTIVE_I,
    input  wire logic         RETRY_TIMER_EXPIRED_I,
    input  wire logic         REPLAY_ROLLOVER_I,
    input  wire logic [127:0] ERR_HEADER_I,
    input  wire logic         COR_REPORT_EN_I,
    input  wire logic         UNCOR_ERR_I,
    input  wire logic [4:0]   UNCOR_ERR_POS_I,
    input  wire logic         UNCOR_PTR_REARM_I,
    output logic              COR_MSG_O,
    output logic              END_TO_END_CRC_CHECK_ENABLE_O,
    output logic              END_TO_END_CRC_GENERATE_ENABLE_O
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [cer_pkg::SYNC_STAGES-1:0] link_sync;
    logic [cer_pkg::SYNC_STAGES-1:0] global_reset_n_sync;
    logic                            soft_rst;
    logic [31:0]                     flags;
    logic [31:0]                     masks;
    logic [31:0]                     ctrl;
    logic [31:0]                     hdr_log [cer_pkg::HDR_WORDS];
    logic                            ptr_armed;
    logic [31:0]                     be_bits;
    logic                            wr_flags;
    logic                            wr_masks;
    logic                            wr_ctrl;
    logic [31:0]                     clr;
    logic [31:0]                     next_flags;
    logic [31:0]                     next_rdata;
    logic [31:0]                     ctrl_wr_val;

    cer_evt_if evt ();

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
        reg_hit = (addr[11:2] == off[11:2]);
    endfunction : reg_hit

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdata,
                                          input logic [31:0] lanes,
                                          input logic [31:0] rw);
        logic [31:0] sel;
        sel   = lanes & rw;
        merge = (old & ~sel) | (wdata & sel);
    endfunction : merge

    // ------------------------------------------------------------------
    // Reset pin synchronisers
    // ------------------------------------------------------------------
    // Both reset pins are asynchronous to CLK_I, so they are resynchronised
    // and act as a synchronous clear; the power-on reset stays asynchronous.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            link_sync <= '0;
        end else begin
            link_sync <= {link_sync[cer_pkg::SYNC_STAGES-2:0], LINK_RESET_N_I};
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            global_reset_n_sync <= '0;
        end else begin
            global_reset_n_sync <= {global_reset_n_sync[cer_pkg::SYNC_STAGES-2:0],
                                    GLOBAL_RESET_N_I};
        end
    end

    assign soft_rst = !link_sync[cer_pkg::SYNC_STAGES-1]
                    || !global_reset_n_sync[cer_pkg::SYNC_STAGES-1];

    // ------------------------------------------------------------------
    // Event gating
    // ------------------------------------------------------------------
    assign evt.decode_err  = PHY_DECODE_ERR_I;
    assign evt.dllp_active = RX_DLLP_ACTIVE_I;
    assign evt.tlp_active  = RX_TLP_ACTIVE_I;
    assign evt.timer_exp   = RETRY_TIMER_EXPIRED_I;
    assign evt.rollover    = REPLAY_ROLLOVER_I;
    assign evt.mask        = masks;

    cer_gate u_gate (
        .evt (evt.gate)
    );

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    assign be_bits  = {{8{CFG_BE_I[3]}}, {8{CFG_BE_I[2]}}, {8{CFG_BE_I[1]}}, {8{CFG_BE_I[0]}}};
    assign wr_flags = CFG_WR_I && reg_hit(CFG_ADDR_I, cer_pkg::OFF_FLAGS);
    assign wr_masks = CFG_WR_I && reg_hit(CFG_ADDR_I, cer_pkg::OFF_MASKS);
    assign wr_ctrl  = CFG_WR_I && reg_hit(CFG_ADDR_I, cer_pkg::OFF_CTRL);
    assign ctrl_wr_val = merge(ctrl, CFG_WDATA_I, be_bits, cer_pkg::CTRL_RW);

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // only a written one clears
    assign clr = wr_flags ? (CFG_WDATA_I & be_bits & cer_pkg::ERR_IMPL) : 32'h0000_0000;
    // A new event in the clearing cycle wins, so no error is lost.
    assign next_flags = ((flags & ~clr) | evt.set) & cer_pkg::ERR_IMPL;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flags <= cer_pkg::FLAGS_RST;
        end else if (soft_rst) begin
            flags <= cer_pkg::FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------------
    // Mask register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            masks <= cer_pkg::MASKS_RST;
        end else if (soft_rst) begin
            masks <= cer_pkg::MASKS_RST;
        end else if (wr_masks) begin
            masks <= merge(masks, CFG_WDATA_I, be_bits, cer_pkg::ERR_IMPL);
        end
    end

    // ------------------------------------------------------------------
    // Capability and control register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl <= cer_pkg::CTRL_RST;
        end else if (soft_rst) begin
            ctrl <= cer_pkg::CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl[cer_pkg::BIT_CHK_EN] <= ctrl_wr_val[cer_pkg::BIT_CHK_EN];
                ctrl[cer_pkg::BIT_GEN_EN] <= ctrl_wr_val[cer_pkg::BIT_GEN_EN];
            end
            if (UNCOR_ERR_I && !ptr_armed) begin
                ctrl[cer_pkg::PTR_LSB +: cer_pkg::PTR_W] <= UNCOR_ERR_POS_I;
            end
        end
    end

    // The pointer stays frozen until the uncorrectable side rearms it,
    // which it does once software has cleared the pointed status bit.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ptr_armed <= 1'b0;
        end else if (soft_rst) begin
            ptr_armed <= 1'b0;
        end else if (UNCOR_ERR_I) begin
            ptr_armed <= 1'b1;
        end else if (UNCOR_PTR_REARM_I) begin
            ptr_armed <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Header log
    // ------------------------------------------------------------------
    genvar gw;
    generate
        for (gw = 0; gw < cer_pkg::HDR_WORDS; gw++) begin : g_hdr
            always_ff @(posedge CLK_I or negedge RSTN_I) begin
                if (!RSTN_I) begin
                    hdr_log[gw] <= cer_pkg::HDR_RST;
                end else if (soft_rst) begin
                    hdr_log[gw] <= cer_pkg::HDR_RST;
                end else if (evt.hit) begin
                    hdr_log[gw] <= ERR_HEADER_I[gw*32 +: 32];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = cer_pkg::UNMAPPED;
        if (reg_hit(CFG_ADDR_I, cer_pkg::OFF_FLAGS)) begin
            next_rdata = flags;
        end else if (reg_hit(CFG_ADDR_I, cer_pkg::OFF_MASKS)) begin
            next_rdata = masks;
        end else if (reg_hit(CFG_ADDR_I, cer_pkg::OFF_CTRL)) begin
            next_rdata = ctrl;
            next_rdata[cer_pkg::BIT_CHK_CAP] = 1'b1;
            next_rdata[cer_pkg::BIT_GEN_CAP] = 1'b1;
        end else begin
            for (int w = 0; w < cer_pkg::HDR_WORDS; w++) begin
                if (reg_hit(CFG_ADDR_I, cer_pkg::OFF_HDR0 + 12'(w * 4))) begin
                    next_rdata = hdr_log[w];
                end
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            CFG_RDATA_O  <= cer_pkg::UNMAPPED;
            CFG_RVALID_O <= 1'b0;
        end else begin
            CFG_RDATA_O  <= CFG_RD_I ? next_rdata : cer_pkg::UNMAPPED;
            CFG_RVALID_O <= CFG_RD_I;
        end
    end

    // ------------------------------------------------------------------
    // Outputs to the link layer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            COR_MSG_O <= 1'b0;
        end else begin
            COR_MSG_O <= evt.hit && COR_REPORT_EN_I && !soft_rst;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            END_TO_END_CRC_CHECK_ENABLE_O    <= 1'b0;
            END_TO_END_CRC_GENERATE_ENABLE_O <= 1'b0;
        end else begin
            END_TO_END_CRC_CHECK_ENABLE_O    <= ctrl[cer_pkg::BIT_CHK_EN];
            END_TO_END_CRC_GENERATE_ENABLE_O <= ctrl[cer_pkg::BIT_GEN_EN];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_w1c_clear: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        (wr_flags && CFG_BE_I[0] && CFG_WDATA_I[0] && !evt.set[0]) |=> !flags[0]
    ) else $error("receiver error flag not cleared by a written one");

    chk_no_self_clear: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        !wr_flags |=> ((flags & $past(flags)) == $past(flags))
    ) else $error("status flag cleared without a software write");

    chk_timer_set: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        (RETRY_TIMER_EXPIRED_I && !masks[cer_pkg::BIT_TIMER_EXP])
            |=> flags[cer_pkg::BIT_TIMER_EXP]
    ) else $error("timer expiry flag not set");

    chk_rollover_set: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        (REPLAY_ROLLOVER_I && !masks[cer_pkg::BIT_ROLLOVER]) |=> flags[cer_pkg::BIT_ROLLOVER]
    ) else $error("rollover flag not set");

    chk_dllp_set: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        (PHY_DECODE_ERR_I && RX_DLLP_ACTIVE_I && !masks[cer_pkg::BIT_DLLP_ERR])
            |=> flags[cer_pkg::BIT_DLLP_ERR]
    ) else $error("link packet decode flag not set");

    chk_tlp_set: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        (PHY_DECODE_ERR_I && RX_TLP_ACTIVE_I && !masks[cer_pkg::BIT_TLP_ERR])
            |=> flags[cer_pkg::BIT_TLP_ERR]
    ) else $error("transaction packet decode flag not set");

    chk_rx_set: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        (PHY_DECODE_ERR_I && !masks[cer_pkg::BIT_RX_ERR]) |=> flags[cer_pkg::BIT_RX_ERR]
    ) else $error("receiver error flag not set");

    chk_reserved_zero: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        ((flags | masks) & ~cer_pkg::ERR_IMPL) == 32'h0000_0000
    ) else $error("reserved status or mask bit is set");

    chk_mask_blocks: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        ##1 ((flags & ~$past(flags) & $past(masks)) == 32'h0000_0000)
    ) else $error("masked error set its status flag");

    chk_cap_bits: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (CFG_RD_I && reg_hit(CFG_ADDR_I, cer_pkg::OFF_CTRL))
            |=> (CFG_RVALID_O && CFG_RDATA_O[cer_pkg::BIT_CHK_CAP]
                 && CFG_RDATA_O[cer_pkg::BIT_GEN_CAP])
    ) else $error("capability bits do not read as one");

    chk_ptr_hold: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        (ptr_armed && !wr_ctrl) |=> $stable(ctrl[cer_pkg::PTR_LSB +: cer_pkg::PTR_W])
    ) else $error("first error pointer moved while held");

    chk_soft_reset: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        soft_rst |=> (flags == cer_pkg::FLAGS_RST && masks == cer_pkg::MASKS_RST
                      && ctrl == cer_pkg::CTRL_RST)
    ) else $error("registers not restored by link or global reset");

    chk_hdr_load: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        evt.hit |=> (hdr_log[0] == $past(ERR_HEADER_I[31:0]))
    ) else $error("header log not loaded on unmasked error");

    chk_msg_pulse: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I || soft_rst)
        (evt.hit && COR_REPORT_EN_I) |=> COR_MSG_O ##1 (!COR_MSG_O || $past(evt.hit))
    ) else $error("correctable message not sent for unmasked error");

endmodule : cer_regs

/* logic/cer_pkg.sv */
// Summary of operation
// - Status bits clear only on a written one or a link, global or power-on reset; error events never clear them.
// - Status bit 12 sets when the retry timer expires unacknowledged.
// - Status bit 8 sets when the replay attempt counter wraps.
// - Status bit 7 sets on a decode error during link packet reception.
// - Status bit 6 sets on a decode error during transaction packet reception.
// - Status bit 0 sets on any physical layer decode error.
// - Unused status and mask bits read zero and ignore writes.
// - A set mask bit blocks status, message and header log update; the pointer follows the uncorrectable side only.
// - Mask bits 12, 8, 7, 6 and 0 are read/write, reset to zero.
// - Control bit 8 enables end-to-end CRC checking of received packets.
// - Control bit 7 always reads one, showing check support.
// - Control bit 6 enables end-to-end CRC generation on transmit.
// - Control bit 5 always reads one, showing generation support.
// - Control bits 4:0 point at the first detected uncorrectable error.
// - Link reset, global reset or power-on reset restore all defaults.
// - Registers sit at 110h, 114h, 118h; control resets to 0000 00A0h.
// - Unmasked errors load the packet header log starting at 11Ch.
package cer_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_FLAGS = 12'h110;
    localparam logic [11:0] OFF_MASKS = 12'h114;
    localparam logic [11:0] OFF_CTRL  = 12'h118;
    localparam logic [11:0] OFF_HDR0  = 12'h11C;
    localparam int          HDR_WORDS = 4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_RX_ERR    = 0;
    localparam int BIT_TLP_ERR   = 6;
    localparam int BIT_DLLP_ERR  = 7;
    localparam int BIT_ROLLOVER  = 8;
    localparam int BIT_TIMER_EXP = 12;
    localparam int BIT_CHK_EN    = 8;
    localparam int BIT_CHK_CAP   = 7;
    localparam int BIT_GEN_EN    = 6;
    localparam int BIT_GEN_CAP   = 5;
    localparam int PTR_LSB       = 0;
    localparam int PTR_W         = 5;

    // ------------------------------------------------------------------
    // Implemented bits and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] ERR_IMPL   = 32'h0000_11C1;
    localparam logic [31:0] CTRL_RW    = 32'h0000_0140;
    localparam logic [31:0] FLAGS_RST  = 32'h0000_0000;
    localparam logic [31:0] MASKS_RST  = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST   = 32'h0000_00A0;
    localparam logic [31:0] HDR_RST    = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED   = 32'h0000_0000;
    localparam int          SYNC_STAGES = 2;

endpackage : cer_pkg

/* logic/cer_evt_if.sv */
`timescale 1ns/1ps
interface cer_evt_if;
    logic        decode_err;
    logic        dllp_active;
    logic        tlp_active;
    logic        timer_exp;
    logic        rollover;
    logic [31:0] mask;
    logic [31:0] set;
    logic        hit;

    modport src (
        output decode_err, dllp_active, tlp_active, timer_exp, rollover, mask,
        input  set, hit
    );
    modport gate (
        input  decode_err, dllp_active, tlp_active, timer_exp, rollover, mask,
        output set, hit
    );
endinterface : cer_evt_if

/* logic/cer_gate.sv */
`timescale 1ns/1ps
module cer_gate (
    cer_evt_if.gate evt
);
    logic [31:0] raw;

    // ------------------------------------------------------------------
    // Event mapping
    // ------------------------------------------------------------------
    always_comb begin
        raw = 32'h0000_0000;
        raw[cer_pkg::BIT_TIMER_EXP] = evt.timer_exp;
        raw[cer_pkg::BIT_ROLLOVER]  = evt.rollover;
        raw[cer_pkg::BIT_DLLP_ERR]  = evt.decode_err & evt.dllp_active;
        raw[cer_pkg::BIT_TLP_ERR]   = evt.decode_err & evt.tlp_active;
        raw[cer_pkg::BIT_RX_ERR]    = evt.decode_err;
    end

    // ------------------------------------------------------------------
    // Masking
    // ------------------------------------------------------------------
    // masked events are dropped here
    assign evt.set = raw & ~evt.mask & cer_pkg::ERR_IMPL;
    assign evt.hit = |evt.set;

endmodule : cer_gate

/* tb/cer_link_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link and PHY event source
// ----------------------------------------------------------------
module cer_link_model (
    input  wire logic         clk_i,
    output logic              decode_err_o,
    output logic              dllp_active_o,
    output logic              tlp_active_o,
    output logic              timer_exp_o,
    output logic              rollover_o,
    output logic      [127:0] hdr_o
);
    initial begin
        {decode_err_o, dllp_active_o, tlp_active_o, timer_exp_o, rollover_o} = 5'h00;
        hdr_o = '0;
    end

    // Kinds: bit0 decode error, bit1 link packet, bit2 transaction packet,
    // bit3 retry timer, bit4 replay wrap. The header only holds for one cycle;
    // afterwards it is inverted so that a late capture cannot pass unseen.
    task automatic send(input logic [4:0] kinds, input logic [127:0] hdr);
        @(negedge clk_i);
        {rollover_o, timer_exp_o, tlp_active_o, dllp_active_o, decode_err_o} = kinds;
        hdr_o = hdr;
        @(negedge clk_i);
        {decode_err_o, dllp_active_o, tlp_active_o, timer_exp_o, rollover_o} = 5'h00;
        hdr_o = ~hdr;
    endtask : send
endmodule : cer_link_model

/* tb/cer_regs_tb_top.sv */
`timescale 1ns/1ps
module cer_regs_tb_top;
    logic clk = 1'b0, rstn = 1'b0, lnk_n = 1'b1, glb_n = 1'b1;
    logic wr = 1'b0, rd = 1'b0, rep_en = 1'b0, uerr = 1'b0, rearm = 1'b0;
    logic [11:0] addr = '0;
    logic [3:0] be = '0;
    logic [31:0] wdata = '0, rdata;
    logic [4:0] upos = '0;
    logic rvalid, msg, chk_en, gen_en, dec, dl, tl, tmo, rol;
    logic [127:0] hdr;
    int err_count = 0, samples_checked = 0;

    always #50 clk = ~clk;

    cer_link_model link_u (.clk_i(clk), .decode_err_o(dec), .dllp_active_o(dl),
        .tlp_active_o(tl), .timer_exp_o(tmo), .rollover_o(rol), .hdr_o(hdr));

    cer_regs dut_u (.CLK_I(clk), .RSTN_I(rstn), .LINK_RESET_N_I(lnk_n),
        .GLOBAL_RESET_N_I(glb_n), .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_ADDR_I(addr),
        .CFG_BE_I(be), .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid),
        .PHY_DECODE_ERR_I(dec), .RX_DLLP_ACTIVE_I(dl), .RX_TLP_ACTIVE_I(tl),
        .RETRY_TIMER_EXPIRED_I(tmo), .REPLAY_ROLLOVER_I(rol), .ERR_HEADER_I(hdr),
        .COR_REPORT_EN_I(rep_en), .UNCOR_ERR_I(uerr), .UNCOR_ERR_POS_I(upos),
        .UNCOR_PTR_REARM_I(rearm), .COR_MSG_O(msg),
        .END_TO_END_CRC_CHECK_ENABLE_O(chk_en),
        .END_TO_END_CRC_GENERATE_ENABLE_O(gen_en));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : check

    task automatic cfg_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
        @(negedge clk);
        {wr, addr, wdata, be} = {1'b1, a, d, b};
        @(negedge clk);
        wr = 1'b0;
    endtask : cfg_wr

    // Read data stands for one cycle only, so it is judged at the next low phase.
    task automatic cfg_rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(negedge clk);
        {rd, addr} = {1'b1, a};
        @(negedge clk);
        rd = 1'b0;
        check(32'h0000_0001, {31'h0, rvalid});
        check(exp, rdata);
    endtask : cfg_rd_chk

    task automatic uncor(input logic e, input logic r, input logic [4:0] p);
        @(negedge clk);
        {uerr, rearm, upos} = {e, r, p};
        @(negedge clk);
        {uerr, rearm} = 2'b00;
    endtask : uncor

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values;
        cfg_rd_chk(12'h110, 32'h0000_0000);
        cfg_rd_chk(12'h114, 32'h0000_0000);
        cfg_rd_chk(12'h118, 32'h0000_00A0);
        cfg_rd_chk(12'h200, 32'h0000_0000);
    endtask : t_reset_values

    task automatic t_clear_on_one;
        link_u.send(5'h1F, {4{32'hA5A5_5A5A}});
        cfg_rd_chk(12'h110, 32'h0000_11C1);
        cfg_wr(12'h110, 32'h0000_0000, 4'hF);
        cfg_rd_chk(12'h110, 32'h0000_11C1);
        cfg_wr(12'h110, 32'h0000_1000, 4'hF);
        cfg_rd_chk(12'h110, 32'h0000_01C1);
        cfg_wr(12'h110, 32'hFFFF_FFFF, 4'hF);
        cfg_rd_chk(12'h110, 32'h0000_0000);
    endtask : t_clear_on_one

    task automatic t_decode_report;
        rep_en = 1'b0;
        link_u.send(5'h05, {32'h4444_4444, 64'h0, 32'h1111_1111});
        check(32'h0000_0000, {31'h0, msg});
        cfg_rd_chk(12'h110, 32'h0000_0041);
        rep_en = 1'b1;
        link_u.send(5'h03, {32'hDDDD_0004, 64'h0, 32'hCAFE_0001});
        check(32'h0000_0001, {31'h0, msg});
        cfg_rd_chk(12'h110, 32'h0000_00C1);
        cfg_rd_chk(12'h11C, 32'hCAFE_0001);
        cfg_rd_chk(12'h128, 32'hDDDD_0004);
        cfg_wr(12'h110, 32'hFFFF_FFFF, 4'hF);
    endtask : t_decode_report

    task automatic t_mask;
        cfg_wr(12'h114, 32'hFFFF_FFFF, 4'hF);
        cfg_rd_chk(12'h114, 32'h0000_11C1);
        link_u.send(5'h1B, {4{32'h0BAD_0BAD}});
        check(32'h0000_0000, {31'h0, msg});
        cfg_rd_chk(12'h110, 32'h0000_0000);
        cfg_rd_chk(12'h11C, 32'hCAFE_0001);
        cfg_wr(12'h114, 32'h0000_0000, 4'h2);
        cfg_rd_chk(12'h114, 32'h0000_00C1);
        link_u.send(5'h0B, {4{32'h1234_5678}});
        check(32'h0000_0001, {31'h0, msg});
        cfg_rd_chk(12'h110, 32'h0000_1000);
        cfg_wr(12'h114, 32'h0000_0000, 4'hF);
        cfg_wr(12'h110, 32'hFFFF_FFFF, 4'hF);
    endtask : t_mask

    task automatic t_control;
        cfg_wr(12'h118, 32'hFFFF_FFFF, 4'hF);
        cfg_rd_chk(12'h118, 32'h0000_01E0);
        check(32'h0000_0003, {30'h0, chk_en, gen_en});
        uncor(1'b1, 1'b0, 5'h13);
        uncor(1'b1, 1'b0, 5'h05);
        cfg_rd_chk(12'h118, 32'h0000_01F3);
        uncor(1'b0, 1'b1, 5'h00);
        uncor(1'b1, 1'b0, 5'h05);
        cfg_wr(12'h118, 32'h0000_0000, 4'hF);
        cfg_rd_chk(12'h118, 32'h0000_00A5);
        check(32'h0000_0000, {30'h0, chk_en, gen_en});
    endtask : t_control

    // Both soft reset pins pass a two-flop chain, so each is held for 4 cycles.
    task automatic t_soft_reset;
        for (int i = 0; i < 2; i++) begin
            cfg_wr(12'h118, 32'h0000_0140, 4'hF);
            cfg_wr(12'h114, 32'h0000_1000, 4'hF);
            link_u.send(5'h01, {4{32'h7777_7777}});
            @(negedge clk);
            if (i == 0) lnk_n = 1'b0; else glb_n = 1'b0;
            repeat (4) @(negedge clk);
            {lnk_n, glb_n} = 2'b11;
            repeat (4) @(negedge clk);
            cfg_rd_chk(12'h110, 32'h0000_0000);
            cfg_rd_chk(12'h114, 32'h0000_0000);
            cfg_rd_chk(12'h118, 32'h0000_00A0);
            cfg_rd_chk(12'h11C, 32'h0000_0000);
            check(32'h0000_0000, {30'h0, chk_en, gen_en});
        end
    endtask : t_soft_reset

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset_values();
        t_clear_on_one();
        t_decode_report();
        t_mask();
        t_control();
        t_soft_reset();
        print_verdict();
    end

    // The scenarios need well under 300 cycles; 3000 leaves a wide margin.
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        print_verdict();
    end
endmodule : cer_regs_tb_top
